//--- est_pkg.sv
// Shared types and constants for the event-state timer.
// Assumes a single system clock; all configuration arrives as static inputs.
package est_pkg;

  // Sizes of the unit
  localparam int EST_NEV = 16;
  localparam int EST_NREG = 16;
  localparam int EST_NIN = 8;
  localparam int EST_NOUT = 10;
  localparam int EST_NIO = 18;

  // Reset values
  localparam logic [31:0] EST_CNT_RST = 32'h0000_0000;
  localparam logic [4:0] EST_STATE_RST = 5'h00;
  localparam logic [9:0] EST_OUT_RST = 10'h000;
  localparam logic [31:0] EST_CAP_RST = 32'h0000_0000;

  // Counter tops for the two widths
  localparam logic [31:0] EST_TOP16 = 32'h0000_FFFF;
  localparam logic [31:0] EST_TOP32 = 32'hFFFF_FFFF;

  // Input or output condition of an event
  typedef enum logic [1:0] {
    EST_IO_LOW = 2'h0,
    EST_IO_RISE = 2'h1,
    EST_IO_FALL = 2'h2,
    EST_IO_HIGH = 2'h3
  } est_iocond_type;

  // How match and io terms combine
  typedef enum logic [1:0] {
    EST_CMB_OR = 2'h0,
    EST_CMB_MATCH = 2'h1,
    EST_CMB_IO = 2'h2,
    EST_CMB_AND = 2'h3
  } est_comb_type;

  // Count direction qualifier
  typedef enum logic [1:0] {
    EST_DIR_ANY = 2'h0,
    EST_DIR_UP = 2'h1,
    EST_DIR_DOWN = 2'h2
  } est_dirq_type;

  // One event's definition and its actions
  typedef struct packed {
    logic [31:0] states;
    logic [3:0] msel;
    logic [4:0] iosel;
    est_iocond_type iocond;
    est_comb_type comb;
    est_dirq_type dirq;
    logic hold;
    logic ctr_h;
    logic start;
    logic stop;
    logic halt;
    logic limit;
    logic [9:0] oset;
    logic [9:0] oclr;
    logic [15:0] cap;
    logic irq;
    logic dma;
    logic st_ld;
    logic [4:0] st_nx;
  } est_evt_type;

  // Unit-wide configuration
  typedef struct packed {
    logic split;
    logic [1:0] bidir;
    logic [1:0] autolim;
    logic [1:0] go;
    logic clk_in;
    logic [2:0] clk_sel;
    logic [15:0] cap_regs;
  } est_cfg_type;

endpackage

//--- est_insync.sv
// Input pin synchroniser with edge detection.
// Pins are asynchronous; two flops precede any logic that reads them.
`timescale 1ns/1ps
module est_insync
  import est_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [EST_NIN-1:0] pin,
  output logic [EST_NIN-1:0] lvl,
  output logic [EST_NIN-1:0] rise,
  output logic [EST_NIN-1:0] fall
);
  logic [EST_NIN-1:0] s1_q;
  logic [EST_NIN-1:0] s2_q;
  logic [EST_NIN-1:0] s3_q;

  // Two-stage sync, third stage only for edges
  always_ff @(posedge clk) begin
    if (rst) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else if (ce) begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // Edges seen after synchronisation; a glitch caught at a clock edge still shows as a one-clock pulse
  assign lvl = s2_q;
  assign rise = s2_q & ~s3_q;
  assign fall = ~s2_q & s3_q;
endmodule

//--- est_capmem.sv
// Sixteen-word capture store with one registered read port.
// Several words may take the same value in one cycle.
`timescale 1ns/1ps
module est_capmem
  import est_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [EST_NREG-1:0] we,
  input wire logic [31:0] wdata,
  input wire logic [3:0] raddr,
  output logic [31:0] rdata
);
  logic [31:0] mem [EST_NREG];

  // Capture writes, no reset needed on storage
  always_ff @(posedge clk) begin
    if (ce) begin
      for (int i = 0; i < EST_NREG; i++) begin
        if (we[i]) begin
          mem[i] <= wdata;
        end
      end
    end
  end

  // Read data from a register; shows old word in a write cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      rdata <= EST_CAP_RST;
    end else if (ce) begin
      rdata <= mem[raddr];
    end
  end
endmodule

//--- est_timer.sv
// Event-driven timer and PWM unit: counters, events, state variable.
// Assumes static configuration inputs from logic on CLK; pins are asynchronous.
//
// Summary of operation
// - One 32-bit or two 16-bit, uni/bidirectional counters.
// - Count on system clock or selected input.
// - Sixteen registers, each match or capture.
// - Sixteen events from match, io, or both.
// - Io condition is rise, fall or level.
// - Events start, stop or halt counters directly.
// - Limit clears unidirectional, reverses bidirectional count.
// - Events set, clear or toggle any output.
// - Events copy count into capture registers.
// - Events raise interrupt or DMA requests.
// - Match zero may act as automatic limit.
// - Events qualified by count direction when bidirectional.
// - Match may be held until event fires.
// - Thirty-two states enable events; events change state.
// - State survives counter wrap and limit.
// - Shared-period PWM built from match events.
`timescale 1ns/1ps
module est_timer
  import est_pkg::*;
(
  input wire logic CLK,
  input wire logic RST,
  input wire logic CE,
  input est_pkg::est_cfg_type CFG,
  input est_pkg::est_evt_type [15:0] EVT_CFG,
  input wire logic [15:0][31:0] MATCH_VAL,
  input wire logic [7:0] PIN_IN,
  input wire logic [1:0] UNHALT,
  input wire logic [3:0] CAP_RD_ADDR,
  output logic [9:0] PIN_OUT,
  output logic IRQ,
  output logic DMA_REQ,
  output logic [15:0] EVT_FIRED,
  output logic [4:0] STATE,
  output logic [31:0] COUNT,
  output logic [1:0] DIR_DOWN,
  output logic [1:0] RUNNING,
  output logic [1:0] HALTED,
  output logic [31:0] CAP_RD_DATA
);
  import est_pkg::*;

  // One counting step: returns {direction down, next count}
  function automatic logic [32:0] step(input logic [31:0] c, input logic w16,
                                       input logic lim, input logic bi,
                                       input logic dn);
    logic [31:0] top;
    logic [31:0] n;
    logic d;
    top = w16 ? EST_TOP16 : EST_TOP32;
    d = dn;
    if (bi && lim) begin
      d = ~dn;
    end else if (bi && !dn && c == top) begin
      d = 1'b1;
    end else if (bi && dn && c == 32'h0000_0000) begin
      d = 1'b0;
    end
    if (!bi && lim) begin
      n = 32'h0000_0000;
    end else begin
      n = d ? c - 32'h0000_0001 : c + 32'h0000_0001;
    end
    step = {d, n & top};
  endfunction

  // Io condition test on one selected input or output
  function automatic logic io_hit(input logic [EST_NIO-1:0] lv,
                                  input logic [EST_NIO-1:0] r,
                                  input logic [EST_NIO-1:0] f,
                                  input logic [4:0] sel,
                                  input est_iocond_type cd);
    logic h;
    h = 1'b0;
    if (sel < 5'(EST_NIO)) begin
      unique case (cd)
        EST_IO_LOW: h = ~lv[sel];
        EST_IO_RISE: h = r[sel];
        EST_IO_FALL: h = f[sel];
        EST_IO_HIGH: h = lv[sel];
      endcase
    end
    io_hit = h;
  endfunction

  logic [31:0] cnt_q;
  logic [31:0] cnt_d;
  logic [1:0] run_q;
  logic [1:0] run_d;
  logic [1:0] halt_q;
  logic [1:0] halt_d;
  logic [1:0] dir_q;
  logic [1:0] dir_d;
  logic [4:0] state_q;
  logic [4:0] state_d;
  logic [9:0] out_q;
  logic [9:0] out_d;
  logic [9:0] outp_q;
  logic [15:0] held_q;
  logic [15:0] held_d;
  logic [15:0] fire;
  logic [15:0] fire_q;
  logic irq_q;
  logic dma_q;
  logic [7:0] in_lvl;
  logic [7:0] in_rise;
  logic [7:0] in_fall;
  logic [15:0] match_l;
  logic [15:0] match_h;
  logic tick;
  logic [1:0] act;
  logic [1:0] adv;
  logic [1:0] lim;
  logic [32:0] step_l;
  logic [32:0] step_h;
  logic [EST_NIO-1:0] io_lv;
  logic [EST_NIO-1:0] io_r;
  logic [EST_NIO-1:0] io_f;
  logic [1:0] start_any;
  logic [1:0] stop_any;
  logic [1:0] halt_any;
  logic [1:0] lim_ev;
  logic [9:0] set_any;
  logic [9:0] clr_any;
  logic [15:0] cap_we;
  logic irq_any;
  logic dma_any;
  logic st_ld_any;
  logic [4:0] st_nx_sel;

  est_insync u_insync (
    .clk(CLK),
    .rst(RST),
    .ce(CE),
    .pin(PIN_IN),
    .lvl(in_lvl),
    .rise(in_rise),
    .fall(in_fall)
  );

  // Counter clock: every system clock, or rising edges of one input
  assign tick = CFG.clk_in ? in_rise[CFG.clk_sel] : 1'b1;
  assign act = {tick & ~halt_q[1] & CFG.split, tick & ~halt_q[0]};
  assign adv = act & run_q;

  // Compare each match-type register with its counter
  generate
    for (genvar i = 0; i < EST_NREG; i++) begin : g_match
      assign match_l[i] = ~CFG.cap_regs[i] & (CFG.split ?
        MATCH_VAL[i][15:0] == cnt_q[15:0] : MATCH_VAL[i] == cnt_q);
      assign match_h[i] = ~CFG.cap_regs[i] & CFG.split &
        (MATCH_VAL[i][31:16] == cnt_q[31:16]);
    end
  endgenerate

  // Outputs count as io sources too, edges from their last value
  assign io_lv = {out_q, in_lvl};
  assign io_r = {out_q & ~outp_q, in_rise};
  assign io_f = {~out_q & outp_q, in_fall};

  // Per-event evaluation; all events see the same snapshot
  generate
    for (genvar e = 0; e < EST_NEV; e++) begin : g_evt
      logic c;
      logic raw_m;
      logic m;
      logic io;
      logic dq;
      logic cond;
      assign c = CFG.split & EVT_CFG[e].ctr_h;
      assign raw_m = c ? match_h[EVT_CFG[e].msel] : match_l[EVT_CFG[e].msel];
      assign m = raw_m | held_q[e];
      assign io = io_hit(io_lv, io_r, io_f, EVT_CFG[e].iosel, EVT_CFG[e].iocond);
      assign dq = (EVT_CFG[e].dirq == EST_DIR_UP) ? ~dir_q[c] :
                  (EVT_CFG[e].dirq == EST_DIR_DOWN) ? dir_q[c] : 1'b1;
      assign cond = (EVT_CFG[e].comb == EST_CMB_OR) ? (m | io) :
                    (EVT_CFG[e].comb == EST_CMB_MATCH) ? m :
                    (EVT_CFG[e].comb == EST_CMB_IO) ? io : (m & io);
      assign fire[e] = act[c] & EVT_CFG[e].states[state_q] & dq & cond;
      // New match wins over the clear by firing
      assign held_d[e] = (EVT_CFG[e].hold & raw_m & act[c]) |
                         (held_q[e] & ~fire[e]);
    end
  endgenerate

  // Gather actions of all firing events; later index wins a state load
  always_comb begin
    start_any = 2'h0;
    stop_any = 2'h0;
    halt_any = 2'h0;
    lim_ev = 2'h0;
    set_any = 10'h000;
    clr_any = 10'h000;
    cap_we = 16'h0000;
    irq_any = 1'b0;
    dma_any = 1'b0;
    st_ld_any = 1'b0;
    st_nx_sel = state_q;
    for (int e = 0; e < EST_NEV; e++) begin
      if (fire[e]) begin
        start_any[CFG.split & EVT_CFG[e].ctr_h] |= EVT_CFG[e].start;
        stop_any[CFG.split & EVT_CFG[e].ctr_h] |= EVT_CFG[e].stop;
        halt_any[CFG.split & EVT_CFG[e].ctr_h] |= EVT_CFG[e].halt;
        lim_ev[CFG.split & EVT_CFG[e].ctr_h] |= EVT_CFG[e].limit;
        set_any = set_any | EVT_CFG[e].oset;
        clr_any = clr_any | EVT_CFG[e].oclr;
        cap_we = cap_we | (EVT_CFG[e].cap & CFG.cap_regs);
        irq_any = irq_any | EVT_CFG[e].irq;
        dma_any = dma_any | EVT_CFG[e].dma;
        if (EVT_CFG[e].st_ld) begin
          st_ld_any = 1'b1;
          st_nx_sel = EVT_CFG[e].st_nx;
        end
      end
    end
  end

  // Limit from events or from register zero used as period
  assign lim[0] = lim_ev[0] | (CFG.autolim[0] & match_l[0]);
  assign lim[1] = lim_ev[1] | (CFG.autolim[1] & match_h[0]);

  // Next counts; the high half is only a counter of its own when split
  assign step_l = step(CFG.split ? {16'h0000, cnt_q[15:0]} : cnt_q, CFG.split,
                       lim[0], CFG.bidir[0], dir_q[0]);
  assign step_h = step({16'h0000, cnt_q[31:16]}, 1'b1, lim[1], CFG.bidir[1],
                       dir_q[1]);
  assign cnt_d = CFG.split ?
    {adv[1] ? step_h[15:0] : cnt_q[31:16], adv[0] ? step_l[15:0] : cnt_q[15:0]} :
    (adv[0] ? step_l[31:0] : cnt_q);
  assign dir_d = {adv[1] ? step_h[32] : dir_q[1], adv[0] ? step_l[32] : dir_q[0]};

  // Start beats stop; halt holds until released from outside
  assign run_d = CFG.go | start_any | (run_q & ~stop_any);
  assign halt_d = halt_any | (halt_q & ~UNHALT);

  // Set and clear together toggle; this is what makes dual-edge PWM safe
  assign out_d = (set_any & clr_any & ~out_q) | (set_any & ~clr_any) |
                 (~set_any & ~clr_any & out_q);

  // State moves only by event load, never on wrap or limit
  assign state_d = st_ld_any ? st_nx_sel : state_q;

  // Counter and control registers
  always_ff @(posedge CLK) begin
    if (RST) begin
      cnt_q <= EST_CNT_RST;
      dir_q <= 2'h0;
      run_q <= 2'h0;
      halt_q <= 2'h0;
    end else if (CE) begin
      cnt_q <= cnt_d;
      dir_q <= dir_d;
      run_q <= run_d;
      halt_q <= halt_d;
    end
  end

  // Event results: outputs, state, requests; PWM edges land here
  always_ff @(posedge CLK) begin
    if (RST) begin
      out_q <= EST_OUT_RST;
      outp_q <= EST_OUT_RST;
      state_q <= EST_STATE_RST;
      held_q <= 16'h0000;
      fire_q <= 16'h0000;
      irq_q <= 1'b0;
      dma_q <= 1'b0;
    end else if (CE) begin
      out_q <= out_d;
      outp_q <= out_q;
      state_q <= state_d;
      held_q <= held_d;
      fire_q <= fire;
      irq_q <= irq_any;
      dma_q <= dma_any;
    end
  end

  est_capmem u_capmem (
    .clk(CLK),
    .rst(RST),
    .ce(CE),
    .we(cap_we),
    .wdata(cnt_q),
    .raddr(CAP_RD_ADDR),
    .rdata(CAP_RD_DATA)
  );

  assign PIN_OUT = out_q;
  assign IRQ = irq_q;
  assign DMA_REQ = dma_q;
  assign EVT_FIRED = fire_q;
  assign STATE = state_q;
  assign COUNT = cnt_q;
  assign DIR_DOWN = dir_q;
  assign RUNNING = run_q;
  assign HALTED = halt_q;

  // Checks on the block's own behaviour
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  a_limit_clears: assert property (
    CE && !CFG.split && !CFG.bidir[0] && adv[0] && lim[0] |=> cnt_q == 32'h0000_0000)
    else $error("unidirectional limit did not clear the counter");
  a_limit_reverses: assert property (
    CE && !CFG.split && CFG.bidir[0] && adv[0] && lim[0] |=> dir_q[0] != $past(dir_q[0]))
    else $error("bidirectional limit did not reverse direction");
  a_auto_limit: assert property (
    CE && !CFG.split && !CFG.bidir[0] && adv[0] && CFG.autolim[0] && match_l[0]
    |=> cnt_q == 32'h0000_0000)
    else $error("match zero did not act as limit");
  a_halt_freezes: assert property (
    CE && halt_q[0] && !UNHALT[0] && !CFG.split |=> $stable(cnt_q) && halt_q[0])
    else $error("halted counter moved");
  a_stop_event: assert property (
    CE && stop_any[0] && !start_any[0] && !CFG.go[0] |=> !run_q[0] && !adv[0])
    else $error("stop event did not stop the counter");
  a_out_set: assert property (
    CE && |(set_any & ~clr_any)
    |=> (PIN_OUT & $past(set_any & ~clr_any)) == $past(set_any & ~clr_any))
    else $error("set action did not drive output high");
  a_out_toggle: assert property (
    CE && |(set_any & clr_any)
    |=> ((PIN_OUT ^ $past(out_q)) & $past(set_any & clr_any)) == $past(set_any & clr_any))
    else $error("coinciding set and clear did not toggle");
  a_irq_request: assert property (
    CE && irq_any |=> IRQ && EVT_FIRED != 16'h0000)
    else $error("interrupt request missing after event");
  a_state_load: assert property (
    CE && st_ld_any |=> STATE == $past(st_nx_sel))
    else $error("state not loaded by event");
  a_state_keeps: assert property (
    CE && lim[0] && !st_ld_any |=> $stable(state_q))
    else $error("state changed on counter limit");
endmodule

//--- est_timer_tb.sv
// Self-checking bench for the event-state timer: PWM, up/down, state, capture, split, pin clock.
// Assumes the timer top and its package are compiled first; the bench drives every port itself.
`timescale 1ns/1ps

`define CHK(name, exp, got) \
  begin samples_checked++; if ((got) !== (exp)) begin err_total++; \
  $display("MISMATCH %s exp %0h got %0h", name, exp, got); end end

module est_timer_tb;
  import est_pkg::*;

  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  est_cfg_type cfg = '0;
  est_evt_type [15:0] evt = '0;
  logic [15:0][31:0] mval = '0;
  logic [7:0] pin = 8'h00;
  logic [1:0] unhalt = 2'h0;
  logic [3:0] raddr = 4'h0;
  logic [9:0] pout;
  logic irq;
  logic dma;
  logic [15:0] fired;
  logic [4:0] state;
  logic [31:0] count;
  logic [31:0] capd;
  logic [1:0] dirdn;
  logic [1:0] running;
  logic [1:0] halted;
  // Staging copies, built blocking, then applied on an edge
  est_cfg_type c;
  est_evt_type [15:0] ev;
  logic [15:0][31:0] mv;
  int err_total = 0;
  int samples_checked = 0;

  // Clock enable held high except for the freeze check in the split scenario
  est_timer dut (
    .CLK(clk),
    .RST(rst),
    .CE(ce),
    .CFG(cfg),
    .EVT_CFG(evt),
    .MATCH_VAL(mval),
    .PIN_IN(pin),
    .UNHALT(unhalt),
    .CAP_RD_ADDR(raddr),
    .PIN_OUT(pout),
    .IRQ(irq),
    .DMA_REQ(dma),
    .EVT_FIRED(fired),
    .STATE(state),
    .COUNT(count),
    .DIR_DOWN(dirdn),
    .RUNNING(running),
    .HALTED(halted),
    .CAP_RD_DATA(capd)
  );

  // 100 MHz system clock
  always #5 clk = ~clk;

  task automatic end_of_test();
    $display("Counts: checked %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic hang(input string what);
    err_total++;
    $display("MISMATCH wait %s exp done got timeout", what);
    end_of_test();
  endtask

  // Step whole cycles, then settle past the edge before looking
  task automatic step(input int n = 1);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic apply();
    @(posedge clk);
    cfg <= c;
    evt <= ev;
    mval <= mv;
    #1;
  endtask

  // Match-only event, live in every state
  function automatic est_evt_type mev(input logic [3:0] m);
    est_evt_type e;
    e = '0;
    e.states = 32'hFFFF_FFFF;
    e.msel = m;
    e.comb = EST_CMB_MATCH;
    return e;
  endfunction

  // Reset for four cycles with all stimulus but raddr and ce cleared, then expect idle outputs
  task automatic do_reset();
    c = '0;
    ev = '0;
    mv = '0;
    @(posedge clk);
    rst <= 1'b1;
    cfg <= '0;
    evt <= '0;
    mval <= '0;
    pin <= 8'h00;
    unhalt <= 2'h0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    #1;
    `CHK("reset outs", 1'b1, ({pout, irq, dma, fired, state} === '0))
    `CHK("reset counts", 1'b1, ({count, dirdn, running, halted, capd} === '0))
  endtask

  // Period 4 from automatic limit, output set at 3 and cleared at 1
  task automatic t_pwm();
    int k;
    do_reset();
    mv[0] = 32'h3;
    mv[1] = 32'h1;
    c.autolim = 2'b01;
    c.go = 2'b01;
    ev[0] = mev(4'h0);
    ev[0].oset = 10'h001;
    ev[0].irq = 1'b1;
    ev[1] = mev(4'h1);
    ev[1].oclr = 10'h001;
    ev[1].dma = 1'b1;
    ev[1].st_ld = 1'b1;
    ev[1].st_nx = 5'h07;
    apply();
    for (k = 0; k < 20 && count !== 32'h3; k++) step();
    if (count !== 32'h3) hang("pwm start");
    for (k = 0; k < 8; k++) begin
      step();
      `CHK("pwm count", 32'(k % 4), count)
      `CHK("pwm out", (k % 4 < 2), pout[0])
      `CHK("pwm fired", (k % 4 == 0) ? 16'h1 : (k % 4 == 2) ? 16'h2 : 16'h0, fired)
      `CHK("pwm irq", (k % 4 == 0), irq)
      `CHK("pwm dma", (k % 4 == 2), dma)
    end
    `CHK("pwm state", 5'h07, state)
  endtask

  // Up/down: limit at 3 turns the count, direction-qualified events at 1
  task automatic t_bidir();
    int k;
    do_reset();
    mv[0] = 32'h3;
    mv[1] = 32'h1;
    c.bidir = 2'b01;
    c.autolim = 2'b01;
    c.go = 2'b01;
    ev[2] = mev(4'h1);
    ev[2].dirq = EST_DIR_DOWN;
    ev[2].oset = 10'h002;
    ev[3] = mev(4'h1);
    ev[3].dirq = EST_DIR_UP;
    ev[3].oset = 10'h004;
    apply();
    for (k = 0; k < 20 && count !== 32'h3; k++) step();
    if (count !== 32'h3) hang("bidir peak");
    `CHK("bidir up outs", 2'b10, pout[2:1])
    step();
    `CHK("bidir turn", 32'h2, count)
    `CHK("bidir dir", 2'b01, dirdn)
    step(2);
    `CHK("bidir fired", 16'h0004, fired)
    `CHK("bidir outs", 2'b11, pout[2:1])
  endtask

  // Stop with capture and state load, pin-edge start, halt with toggle, release
  task automatic t_seq();
    int k;
    do_reset();
    mv[0] = 32'h5;
    mv[2] = 32'h9;
    c.cap_regs = 16'h0002;
    c.go = 2'b01;
    ev[0] = mev(4'h0);
    ev[0].stop = 1'b1;
    ev[0].cap = 16'h0002;
    ev[0].st_ld = 1'b1;
    ev[0].st_nx = 5'h03;
    ev[1].states = 32'h0000_0008;
    ev[1].comb = EST_CMB_IO;
    ev[1].iocond = EST_IO_RISE;
    ev[1].start = 1'b1;
    ev[2] = mev(4'h2);
    ev[2].states = 32'h0000_0008;
    ev[2].halt = 1'b1;
    ev[2].oset = 10'h008;
    ev[2].oclr = 10'h008;
    apply();
    c.go = 2'b00;
    apply();
    @(posedge clk) raddr <= 4'h1;
    for (k = 0; k < 20 && count !== 32'h5; k++) step();
    if (count !== 32'h5) hang("seq match");
    step();
    `CHK("seq stop", 2'b00, running)
    `CHK("seq state", 5'h03, state)
    step(2);
    `CHK("seq capture", 32'h5, capd)
    `CHK("seq stopped", 32'h6, count)
    @(posedge clk) pin <= 8'h01;
    for (k = 0; k < 10 && running !== 2'b01; k++) step();
    `CHK("seq rise start", 2'b01, running)
    for (k = 0; k < 20 && halted !== 2'b01; k++) step();
    if (halted !== 2'b01) hang("seq halt");
    step(3);
    `CHK("seq halted", 32'hA, count)
    `CHK("seq toggle", 1'b1, pout[3])
    `CHK("seq state kept", 5'h03, state)
    @(posedge clk) unhalt <= 2'b01;
    step();
    `CHK("seq unhalt", 2'b00, halted)
    @(posedge clk) unhalt <= 2'b00;
  endtask

  // Two 16-bit counters with their own limits from match zero
  task automatic t_split();
    int k;
    do_reset();
    c.split = 1'b1;
    c.autolim = 2'b11;
    c.go = 2'b11;
    mv[0] = {16'h0002, 16'h0004};
    apply();
    for (k = 0; k < 10 && running !== 2'b11; k++) step();
    if (running !== 2'b11) hang("split run");
    for (k = 1; k < 10; k++) begin
      step();
      `CHK("split count", {16'(k % 3), 16'(k % 5)}, count)
    end
    // Clock enable low must freeze both halves
    @(posedge clk) ce <= 1'b0;
    step(3);
    `CHK("split frozen", 32'h0001_0000, count)
    @(posedge clk) ce <= 1'b1;
  endtask

  // Held match waits for a pin level; output rise, pin fall and low level as io terms
  task automatic t_hold();
    do_reset();
    mv[0] = 32'h2;
    c.go = 2'b01;
    ev[0] = mev(4'h0);
    ev[0].hold = 1'b1;
    ev[0].comb = EST_CMB_AND;
    ev[0].iocond = EST_IO_HIGH;
    ev[0].oset = 10'h001;
    ev[1] = mev(4'h0);
    ev[1].comb = EST_CMB_IO;
    ev[1].iosel = 5'h08;
    ev[1].iocond = EST_IO_RISE;
    ev[1].st_ld = 1'b1;
    ev[1].st_nx = 5'h09;
    ev[2] = mev(4'h0);
    ev[2].comb = EST_CMB_IO;
    ev[2].iocond = EST_IO_FALL;
    ev[2].oclr = 10'h001;
    ev[3] = mev(4'h0);
    ev[3].states = 32'h0000_0200;
    ev[3].comb = EST_CMB_IO;
    ev[3].iosel = 5'h01;
    ev[3].iocond = EST_IO_LOW;
    ev[3].dma = 1'b1;
    apply();
    step(6);
    `CHK("hold waits", 1'b0, pout[0])
    `CHK("hold dma idle", 1'b0, dma)
    @(posedge clk) pin <= 8'h01;
    step(4);
    `CHK("hold fires", 1'b1, pout[0])
    `CHK("out rise state", 5'h09, state)
    step();
    `CHK("low level dma", 1'b1, dma)
    @(posedge clk) pin <= 8'h00;
    step(4);
    `CHK("pin fall clear", 1'b0, pout[0])
  endtask

  // Counter clocked by rising edges of input 1 only
  task automatic t_inclk();
    do_reset();
    c.clk_in = 1'b1;
    c.clk_sel = 3'h1;
    c.go = 2'b01;
    apply();
    step(10);
    `CHK("inclk idle", 32'h0, count)
    repeat (5) begin
      @(posedge clk) pin <= 8'h02;
      repeat (3) @(posedge clk);
      pin <= 8'h00;
      repeat (3) @(posedge clk);
    end
    step(4);
    `CHK("inclk count", 32'h5, count)
  endtask

  // Main sequence
  initial begin
    t_pwm();
    t_bidir();
    t_seq();
    t_split();
    t_inclk();
    t_hold();
    end_of_test();
  end
endmodule
